// ===== core/cbc_top.sv
// Behaviour
// RULE_01: Balance duration code 0 means no timeout, 1 one second, 2..9 one to sixty minutes, 10..15 reserved.
// RULE_02: When a non-zero duration expires, all balance enables are switched off.
// RULE_03: The balance timer is its own counter and link traffic never restarts or clears it.
// RULE_04: Every write of a non-zero value to the channel enable register restarts the timer from zero.
// RULE_05: With fault-continue policy 0, any fault except the custom checksum error forces all enables to zero.
// RULE_06: With fault-continue policy 0 and such a fault present, writes to the enable register are discarded.
// RULE_07: With fault-continue policy 1, faults leave the enable register untouched.
// RULE_08: The enable register is 16 bits and bit n drives the output of cell n+1.
// RULE_09: An enable bit of 1 turns balancing or squeeze on for that channel, 0 turns it off.
// RULE_10: In squeeze mode the enable bits drive the open-wire-detection squeeze resistors instead.
// RULE_11: The three low bits of the balance configuration register read as zero and software writes zero.
// RULE_12: Squeeze mode select is bit 4 of the test configuration register.
// RULE_13: One combined fault input, the OR of all faults but the custom checksum error, drives the lockout.
`timescale 1ns/1ps
`include "cbc_regs.svh"

module cbc_top #(
	parameter int unsigned TICK_CYCLES = `CBC_TICK_CYCLES
) (
	input wire logic mclk, // System clock, 50 MHz
	input wire logic rstn, // Async reset, active low
	input wire cbc_pkg::cbc_bus_req_type bus, // Register port request
	output logic [`CBC_DATA_W-1:0] rdata, // Read data, cycle after read strobe
	input wire logic fault_any, // OR of faults except checksum error
	output logic [`CBC_DATA_W-1:0] balance_out, // Per-cell balance drive
	output logic [`CBC_DATA_W-1:0] squeeze_out // Per-cell squeeze resistor drive
);
	import cbc_pkg::*;

	cbc_state_type s_r;
	cbc_state_type s_nxt;
	logic wr_cfg;
	logic wr_en;
	logic wr_test;
	logic lockout;
	logic restart;
	logic expired;

	// Register decode, used for both the write and read paths
	function automatic logic hit(input logic [`CBC_ADDR_W-1:0] a, input logic [`CBC_ADDR_W-1:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	// Fault input is produced on this clock by the fault logic, so no synchroniser
	assign lockout = fault_any && !s_r.policy; // RULE_13

	assign wr_cfg = bus.wr && hit(bus.addr, `CBC_ADDR_BAL_CONFIG);
	assign wr_en = bus.wr && hit(bus.addr, `CBC_ADDR_CH_ENABLE);
	assign wr_test = bus.wr && hit(bus.addr, `CBC_ADDR_TEST_CONFIG);

	// Restart follows the write itself, even a write the lockout discards;
	// the enables are held at zero then anyway, so nothing balances early.
	assign restart = wr_en && (bus.wdata != '0); // RULE_04

	cbc_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.mclk(mclk),
		.rstn(rstn),
		.restart(restart),
		.duration_code(s_r.duration),
		.expired(expired)
	);

	always_comb begin
		s_nxt = s_r;

		if (wr_cfg) begin
			s_nxt.duration = bus.wdata[`CBC_DUR_MSB:`CBC_DUR_LSB]; // RULE_01
			s_nxt.policy = bus.wdata[`CBC_POLICY_BIT];
		end
		if (wr_test) begin
			s_nxt.squeeze = bus.wdata[`CBC_SQUEEZE_BIT]; // RULE_12
		end

		// Priority: fault lockout, then a fresh write, then timer expiry
		if (lockout) begin
			s_nxt.ch_en = '0; // RULE_05 RULE_06
		end else if (wr_en) begin
			s_nxt.ch_en = bus.wdata; // RULE_07 RULE_09
		end else if (expired) begin
			s_nxt.ch_en = '0; // RULE_02
		end

		// Outputs follow the next enable value so pins match the register
		if (s_nxt.squeeze) begin
			s_nxt.bal_out = '0;
			s_nxt.sqz_out = s_nxt.ch_en; // RULE_10
		end else begin
			s_nxt.bal_out = s_nxt.ch_en; // RULE_08 RULE_09
			s_nxt.sqz_out = '0;
		end

		// Read data stands one cycle; unmapped addresses read zero
		s_nxt.rdata = '0;
		if (bus.rd) begin
			if (hit(bus.addr, `CBC_ADDR_BAL_CONFIG)) begin
				s_nxt.rdata[`CBC_DUR_MSB:`CBC_DUR_LSB] = s_r.duration;
				s_nxt.rdata[`CBC_POLICY_BIT] = s_r.policy;
				s_nxt.rdata[`CBC_RSVD_MSB:0] = '0; // RULE_11
			end else if (hit(bus.addr, `CBC_ADDR_CH_ENABLE)) begin
				s_nxt.rdata = s_r.ch_en;
			end else if (hit(bus.addr, `CBC_ADDR_TEST_CONFIG)) begin
				s_nxt.rdata[`CBC_SQUEEZE_BIT] = s_r.squeeze;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_r.duration <= `CBC_DUR_RESET;
			s_r.policy <= `CBC_POLICY_RESET;
			s_r.ch_en <= `CBC_ENABLE_RESET;
			s_r.squeeze <= `CBC_SQUEEZE_RESET;
			s_r.rdata <= '0;
			s_r.bal_out <= '0;
			s_r.sqz_out <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;
	assign balance_out = s_r.bal_out;
	assign squeeze_out = s_r.sqz_out;

	property p_fault_clear;
		@(posedge mclk) disable iff (!rstn)
		fault_any && !s_r.policy |=> (s_r.ch_en == '0) && (balance_out == '0) && (squeeze_out == '0);
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("enables survived a fault"); // RULE_05

	property p_write_discard;
		@(posedge mclk) disable iff (!rstn)
		wr_en && fault_any && !s_r.policy ##1 !wr_en [*2] |=> s_r.ch_en == '0;
	endproperty
	a_write_discard: assert property (p_write_discard) else $error("locked write was taken"); // RULE_06

	property p_write_taken;
		@(posedge mclk) disable iff (!rstn)
		wr_en && !lockout |=> s_r.ch_en == $past(bus.wdata);
	endproperty
	a_write_taken: assert property (p_write_taken) else $error("enable write lost"); // RULE_09

	property p_continue;
		@(posedge mclk) disable iff (!rstn)
		s_r.policy && fault_any && !wr_en && !wr_cfg && !expired |=> s_r.ch_en == $past(s_r.ch_en);
	endproperty
	a_continue: assert property (p_continue) else $error("fault changed enables under continue policy"); // RULE_07

	property p_expire;
		@(posedge mclk) disable iff (!rstn)
		expired && !wr_en |=> s_r.ch_en == '0;
	endproperty
	a_expire: assert property (p_expire) else $error("enables kept after timeout"); // RULE_02

	property p_out_map;
		@(posedge mclk) disable iff (!rstn)
		((balance_out | squeeze_out) == s_r.ch_en) && ((balance_out & squeeze_out) == '0);
	endproperty
	a_out_map: assert property (p_out_map) else $error("outputs do not mirror enables"); // RULE_08

	property p_squeeze_route;
		@(posedge mclk) disable iff (!rstn)
		s_r.squeeze |-> (balance_out == '0) && (squeeze_out == s_r.ch_en);
	endproperty
	a_squeeze_route: assert property (p_squeeze_route) else $error("squeeze mode drove balance pins"); // RULE_10

	property p_squeeze_bit;
		@(posedge mclk) disable iff (!rstn)
		wr_test |=> s_r.squeeze == $past(bus.wdata[`CBC_SQUEEZE_BIT]);
	endproperty
	a_squeeze_bit: assert property (p_squeeze_bit) else $error("squeeze select not stored"); // RULE_12

	property p_rsvd_read;
		@(posedge mclk) disable iff (!rstn)
		bus.rd && hit(bus.addr, `CBC_ADDR_BAL_CONFIG) |=> rdata[`CBC_RSVD_MSB:0] == '0;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("reserved config bits read nonzero"); // RULE_11

	property p_restart_wr;
		@(posedge mclk) disable iff (!rstn)
		wr_en && (bus.wdata != '0) |=> !expired;
	endproperty
	a_restart_wr: assert property (p_restart_wr) else $error("nonzero write did not restart timer"); // RULE_04

	property p_duration_read;
		@(posedge mclk) disable iff (!rstn)
		wr_cfg ##1 !wr_cfg ##1 bus.rd && hit(bus.addr, `CBC_ADDR_BAL_CONFIG)
			|=> rdata[`CBC_DUR_MSB:`CBC_DUR_LSB] == $past(bus.wdata[`CBC_DUR_MSB:`CBC_DUR_LSB], 3);
	endproperty
	a_duration_read: assert property (p_duration_read) else $error("duration code readback wrong"); // RULE_01

	property p_fault_single;
		@(posedge mclk) disable iff (!rstn)
		!fault_any && !wr_en && !expired && !wr_cfg |=> s_r.ch_en == $past(s_r.ch_en);
	endproperty
	a_fault_single: assert property (p_fault_single) else $error("enables changed without cause"); // RULE_13

endmodule

// ===== core/cbc_regs.svh
`ifndef CBC_REGS_SVH
`define CBC_REGS_SVH

// Register map (plain port, printed offsets)
`define CBC_ADDR_W 8
`define CBC_DATA_W 16
`define CBC_ADDR_BAL_CONFIG 8'h13
`define CBC_ADDR_CH_ENABLE 8'h14
`define CBC_ADDR_TEST_CONFIG 8'h1E

// Field positions
`define CBC_DUR_MSB 7
`define CBC_DUR_LSB 4
`define CBC_POLICY_BIT 3
`define CBC_RSVD_MSB 2
`define CBC_SQUEEZE_BIT 4

// Reset values
`define CBC_DUR_RESET 4'h0
`define CBC_POLICY_RESET 1'b0
`define CBC_ENABLE_RESET 16'h0000
`define CBC_SQUEEZE_RESET 1'b0

// Timing
`define CBC_CLK_PERIOD_NS 20
`define CBC_SECOND_NS 1000000000
`define CBC_TICK_CYCLES (`CBC_SECOND_NS / `CBC_CLK_PERIOD_NS)
`define CBC_PRE_W 32
`define CBC_SEC_W 12
`define CBC_SEC_MAX 12'hFFF

// Auto-off limits in seconds
`define CBC_LIM_NONE 12'h000
`define CBC_LIM_1S 12'h001
`define CBC_LIM_1M 12'h03C
`define CBC_LIM_2M 12'h078
`define CBC_LIM_5M 12'h12C
`define CBC_LIM_10M 12'h258
`define CBC_LIM_15M 12'h384
`define CBC_LIM_20M 12'h4B0
`define CBC_LIM_30M 12'h708
`define CBC_LIM_60M 12'hE10

`endif

// ===== core/cbc_pkg.sv
`include "cbc_regs.svh"

package cbc_pkg;

	typedef struct packed {
		logic [`CBC_ADDR_W-1:0] addr;
		logic [`CBC_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} cbc_bus_req_type;

	typedef struct packed {
		logic [`CBC_PRE_W-1:0] pre;
		logic [`CBC_SEC_W-1:0] sec;
		logic expired;
	} cbc_timer_state_type;

	typedef struct packed {
		logic [3:0] duration;
		logic policy;
		logic [`CBC_DATA_W-1:0] ch_en;
		logic squeeze;
		logic [`CBC_DATA_W-1:0] rdata;
		logic [`CBC_DATA_W-1:0] bal_out;
		logic [`CBC_DATA_W-1:0] sqz_out;
	} cbc_state_type;

endpackage

// ===== core/cbc_timer.sv
`timescale 1ns/1ps
`include "cbc_regs.svh"

module cbc_timer #(
	parameter int unsigned TICK_CYCLES = `CBC_TICK_CYCLES
) (
	input wire logic mclk, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic restart, // Restart count from zero
	input wire logic [3:0] duration_code, // Auto-off selection
	output logic expired // Selected time has run out
);
	import cbc_pkg::*;

	localparam logic [`CBC_PRE_W-1:0] TICK_LAST = `CBC_PRE_W'(TICK_CYCLES - 1);

	cbc_timer_state_type s_r;
	cbc_timer_state_type s_nxt;
	logic [`CBC_SEC_W-1:0] limit;

	// Reserved codes behave as no timeout
	function automatic logic [`CBC_SEC_W-1:0] dur_limit(input logic [3:0] code);
		case (code)
			4'h1: dur_limit = `CBC_LIM_1S;
			4'h2: dur_limit = `CBC_LIM_1M;
			4'h3: dur_limit = `CBC_LIM_2M;
			4'h4: dur_limit = `CBC_LIM_5M;
			4'h5: dur_limit = `CBC_LIM_10M;
			4'h6: dur_limit = `CBC_LIM_15M;
			4'h7: dur_limit = `CBC_LIM_20M;
			4'h8: dur_limit = `CBC_LIM_30M;
			4'h9: dur_limit = `CBC_LIM_60M;
			default: dur_limit = `CBC_LIM_NONE;
		endcase
	endfunction

	// Only a balance enable write restarts it; link traffic has no path in
	always_comb begin
		s_nxt = s_r;
		limit = dur_limit(duration_code); // RULE_01
		if (restart) begin
			s_nxt.pre = '0; // RULE_04
			s_nxt.sec = '0; // RULE_04
		end else if (s_r.pre == TICK_LAST) begin
			s_nxt.pre = '0;
			if (s_r.sec != `CBC_SEC_MAX) begin // RULE_03
				s_nxt.sec = s_r.sec + `CBC_SEC_W'(1);
			end
		end else begin
			s_nxt.pre = s_r.pre + `CBC_PRE_W'(1);
		end
		s_nxt.expired = (limit != `CBC_LIM_NONE) && (s_nxt.sec >= limit); // RULE_02
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign expired = s_r.expired;

	property p_restart;
		@(posedge mclk) disable iff (!rstn)
		restart |=> (s_r.sec == '0) && (s_r.pre == '0) && !expired;
	endproperty
	a_restart: assert property (p_restart) else $error("timer not cleared by restart"); // RULE_04

	property p_tick;
		@(posedge mclk) disable iff (!rstn)
		(s_r.pre == TICK_LAST) && !restart && (s_r.sec != `CBC_SEC_MAX) |=> s_r.sec == $past(s_r.sec) + 1'b1;
	endproperty
	a_tick: assert property (p_tick) else $error("second count did not advance"); // RULE_03

	property p_zero_code;
		@(posedge mclk) disable iff (!rstn)
		(duration_code == 4'h0) ##1 (duration_code == 4'h0) |-> !expired;
	endproperty
	a_zero_code: assert property (p_zero_code) else $error("expired with timer disabled"); // RULE_01

	property p_one_second;
		@(posedge mclk) disable iff (!rstn)
		(duration_code == 4'h1) && (s_r.sec == '0) && (s_r.pre != TICK_LAST) ##1 (duration_code == 4'h1) |-> !expired;
	endproperty
	a_one_second: assert property (p_one_second) else $error("one second code expired early"); // RULE_01

endmodule

// ===== tb/cbc_cell_bank.sv
`timescale 1ns/1ps
// Behavioural bank of external bleed transistors and squeeze resistors, one per cell
module cbc_cell_bank (
	input wire logic [15:0] bal_gate, // Balance transistor gates
	input wire logic [15:0] sqz_gate, // Squeeze resistor selects
	output logic [15:0] cell_drain, // Cells that have current drawn
	output logic clash // One cell driven both ways at once
);
	// A transistor conducts only while its gate is high
	assign cell_drain = bal_gate | sqz_gate;
	// Squeeze and balance share the enables, so never both on one cell
	assign clash = |(bal_gate & sqz_gate);
endmodule

// ===== tb/tb_cell_balance_control.sv
`timescale 1ns/1ps
module tb_cell_balance_control;
	import cbc_pkg::*;
	localparam int TK = 10;
	logic mclk, rstn, fault_any, clash;
	cbc_bus_req_type bus;
	logic [15:0] rdata, balance_out, squeeze_out, cell_drain, d;
	int err_count, total_checks, cyc, seed, m_dur, m_pol, m_en, m_sqz;

	cbc_top #(.TICK_CYCLES(TK)) DUT (.mclk(mclk), .rstn(rstn), .bus(bus), .rdata(rdata),
		.fault_any(fault_any), .balance_out(balance_out), .squeeze_out(squeeze_out));
	cbc_cell_bank u_bank (.bal_gate(balance_out), .sqz_gate(squeeze_out), .cell_drain(cell_drain), .clash(clash));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task close_out;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 10000) begin
			err_count++;
			close_out();
		end
	end

	task idle(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask

	// The model follows the write at the edge that takes it
	task wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge mclk);
		bus.addr <= a;
		bus.wdata <= v;
		bus.wr <= 1'b1;
		@(posedge mclk);
		bus.wr <= 1'b0;
		if (a == 8'h13) begin
			m_dur = v[7:4];
			m_pol = v[3];
		end else if (a == 8'h14 && !(fault_any && m_pol == 0)) begin
			m_en = v;
		end else if (a == 8'h1E) begin
			m_sqz = v[4];
		end
		@(negedge mclk);
	endtask

	task chk_rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge mclk);
		bus.rd <= 1'b0;
		@(negedge mclk);
		total_checks++;
		if (rdata !== e) begin
			err_count++;
			$display("[FAIL] read %h expected %h seen %h", a, e, rdata);
		end
	endtask

	task chk_out;
		logic [15:0] e;
		e = m_en[15:0];
		total_checks++;
		if (balance_out !== (m_sqz ? 16'h0000 : e) || squeeze_out !== (m_sqz ? e : 16'h0000)
			|| cell_drain !== e || clash !== 1'b0) begin
			err_count++;
			$display("[FAIL] outputs expected %h seen %h %h", e, balance_out, squeeze_out);
		end
	endtask

	// Code 0 and reserved codes must never expire
	task timed(input int code, input int lim);
		wr(8'h13, 16'(code << 4));
		wr(8'h14, 16'hA5C3);
		if (lim == 0) begin
			idle(700);
			chk_out();
		end else begin
			idle(lim * TK - 3);
			chk_out();
			idle(7);
			m_en = 0;
			chk_out();
		end
	endtask

	initial begin
		seed = 4;
		rstn = 1'b0;
		bus = '0;
		fault_any = 1'b0;
		{m_dur, m_pol, m_en, m_sqz} = '0;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		idle(1);
		chk_out();
		chk_rd(8'h13, 16'h0000);
		chk_rd(8'h14, 16'h0000);
		chk_rd(8'h1E, 16'h0000);
		wr(8'h13, 16'h0098);
		chk_rd(8'h13, 16'h0098);
		wr(8'h20, 16'hFFFF);
		chk_rd(8'h15, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 16'h0001 : (i == 1) ? 16'h8000 : 16'($random(seed));
			wr(8'h14, d);
			chk_out();
			chk_rd(8'h14, d);
		end
		wr(8'h1E, 16'h0010);
		chk_rd(8'h1E, 16'h0010);
		wr(8'h14, 16'($random(seed)));
		chk_out();
		wr(8'h1E, 16'h0000);
		chk_out();
		wr(8'h13, 16'h0000);
		wr(8'h14, 16'($random(seed)) | 16'h0100);
		@(posedge mclk);
		fault_any <= 1'b1;
		idle(2);
		m_en = 0;
		chk_out();
		wr(8'h14, 16'hFFFF);
		chk_out();
		chk_rd(8'h14, 16'h0000);
		@(posedge mclk);
		fault_any <= 1'b0;
		idle(1);
		chk_out();
		wr(8'h13, 16'h0008);
		wr(8'h14, 16'h3C0F);
		@(posedge mclk);
		fault_any <= 1'b1;
		idle(3);
		chk_out();
		wr(8'h14, 16'hF0F0);
		chk_out();
		@(posedge mclk);
		fault_any <= 1'b0;
		timed(1, 1);
		timed(2, 60);
		timed(0, 0);
		timed(10, 0);
		wr(8'h13, 16'h0010);
		wr(8'h14, 16'h0F00);
		idle(5);
		wr(8'h14, 16'h00F0);
		idle(6);
		chk_out();
		idle(8);
		m_en = 0;
		chk_out();
		// Mid-run reset with squeeze and enables set must bring everything back to zero
		wr(8'h1E, 16'h0010);
		wr(8'h14, 16'h1234);
		@(posedge mclk);
		rstn <= 1'b0;
		idle(2);
		@(posedge mclk);
		rstn <= 1'b1;
		{m_dur, m_pol, m_en, m_sqz} = '0;
		idle(1);
		chk_out();
		chk_rd(8'h1E, 16'h0000);
		chk_rd(8'h14, 16'h0000);
		close_out();
	end
endmodule
